/* rtl/sts_supervisor.sv */
`timescale 1ns/100ps

// Notes on behaviour
// R1 - Modes 4,5: flag xor STO is danger
// R2 - Modes 6-9: flag without STO is danger
// R3 - Danger is trip lock; never auto cleared
// R4 - Bit 30/31 map conditions into status words
// R5 - Safe stop alarm: STO released, then reset
// R6 - Safe stop warning clears when STO released
// R7 - Thermistor alarm: both released, then reset
// R8 - Thermistor warning clears when both released
// R9 - Modes 2,3 ignore the trip flag
// R10 - Card drives safe-stop low on relay open
// R11 - Flag input not reused for motor thermistor
// R12 - STO active low, flag active high; coast
// R13 - Thermistor warning mode restarts without reset
// R14 - Both inputs pass two synchroniser stages
// R15 - Mode field codes 2-9; status latched
module sts_supervisor (
    input  wire logic        i_clk,           // System clock, 100 MHz
    input  wire logic        i_rst,           // Async reset, active high
    input  wire logic        i_hsel,          // AHB slave select
    input  wire logic [31:0] i_haddr,         // AHB address
    input  wire logic [1:0]  i_htrans,        // AHB transfer type
    input  wire logic        i_hwrite,        // AHB write
    input  wire logic [2:0]  i_hsize,         // AHB size (word only)
    input  wire logic [31:0] i_hwdata,        // AHB write data
    input  wire logic        i_hready,        // AHB bus ready
    output logic      [31:0] o_hrdata,        // AHB read data
    output logic             o_hreadyout,     // AHB slave ready
    output logic             o_hresp,         // AHB response, OKAY
    input  wire logic        i_sto_n,         // Safe torque off, low active
    input  wire logic        i_card_trip_flag_output, // Card trip flag, high active
    input  wire logic        i_reset_di,      // Reset request, digital input
    input  wire logic        i_reset_key,     // Reset request, panel key
    output logic             o_coast,         // Motor coast command
    output logic             o_irq            // Interrupt, level high
);

    ////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Word offset of a byte address, low bits dropped
    function automatic logic [7:0] word_ofs(input logic [31:0] a);
        word_ofs = {a[7:2], 2'b00};
    endfunction

    // Thermistor trip in this mode is a latched alarm
    function automatic logic th_is_alarm(input logic [3:0] m);
        th_is_alarm = (m == sts_pkg::MODE_TH_ALARM) || (m == sts_pkg::MODE_TH_ES_ALARM)
                   || (m == sts_pkg::MODE_TH_A_ES_W);
    endfunction

    // Plain safe stop in this mode is a latched alarm
    function automatic logic ss_is_alarm(input logic [3:0] m);
        ss_is_alarm = (m == sts_pkg::MODE_SAFE_ALARM) || (m == sts_pkg::MODE_TH_ES_ALARM)
                   || (m == sts_pkg::MODE_TH_W_ES_A);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisers

    logic [1:0] sync_q;
    logic       sto_act;
    logic       flag_raw;

    // Invert STO so that reset value zero means idle high pin
    sts_sync2 #(
        .W (2)
    ) u_sync (
        .i_clk  (i_clk),
        .i_rst  (i_rst),
        .i_d    ({i_card_trip_flag_output, ~i_sto_n}), // [R14]
        .o_q    (sync_q)
    );

    // STO low is active, flag high is active [R12] [R10]
    assign sto_act  = sync_q[0];
    assign flag_raw = sync_q[1];

    ////////////////////////////////////////////////////////////////////////////
    // State

    sts_pkg::sts_cond_s        cond;
    sts_pkg::sts_cond_s        next_cond;
    logic [3:0]                mode;
    logic [3:0]                next_mode;
    logic [sts_pkg::EV_W-1:0]  irq_st;
    logic [sts_pkg::EV_W-1:0]  next_irq_st;
    logic [sts_pkg::EV_W-1:0]  irq_mask;
    logic [sts_pkg::EV_W-1:0]  next_irq_mask;
    logic                      bus_reset;
    logic                      next_bus_reset;
    sts_pkg::sts_aphase_s      aph;
    sts_pkg::sts_aphase_s      next_aph;
    logic [31:0]               next_hrdata;
    logic                      next_coast;
    logic                      next_irq;

    logic                      flag_act;
    logic                      danger_cond;
    logic                      th_trip;
    logic                      ss_trip;
    logic                      th_mode;
    logic                      reset_req;
    logic                      aphase_ok;
    logic                      wr_ctl;
    logic                      wr_ist;
    logic                      wr_msk;

    ////////////////////////////////////////////////////////////////////////////
    // Condition evaluation

    // Mode codes 2 and 3 have no thermistor card function
    assign th_mode  = (mode >= sts_pkg::MODE_TH_ALARM);
    assign flag_act = flag_raw & th_mode;                       // [R9]

    // Unexpected input pairs depend on whether STO has other sources
    always_comb
    begin
        danger_cond = 1'b0;
        if ((mode == sts_pkg::MODE_TH_ALARM) || (mode == sts_pkg::MODE_TH_WARN))
            danger_cond = flag_act ^ sto_act;                   // [R1]
        else if (th_mode)
            danger_cond = flag_act & ~sto_act;                  // [R2]
    end

    // Card trip shows as both inputs active; STO alone is a plain safe stop except in modes 4 and 5
    assign th_trip   = flag_act & sto_act;                      // [R12]
    assign ss_trip   = sto_act & ~flag_act & ~danger_cond;      // [R2] [R9]
    assign reset_req = i_reset_di | i_reset_key | bus_reset;    // [R5] [R7]

    // Next condition flags; a new trip wins over a reset in the same cycle
    always_comb
    begin
        next_cond = cond;
        // Trip lock: only the hardware reset clears it, no reset request [R3]
        if (danger_cond)
            next_cond.danger = 1'b1;
        // Thermistor alarm or warning by mode [R12] [R15]
        if (th_trip && th_is_alarm(mode))
            next_cond.th_alarm = 1'b1;
        else if (reset_req && !sto_act && !flag_act)
            next_cond.th_alarm = 1'b0;                          // [R7]
        // Warning follows the inputs, no reset request needed [R8] [R13]
        next_cond.th_warn = th_mode && !th_is_alarm(mode) && (sto_act || flag_act)
                          && (th_trip || cond.th_warn);
        // Safe stop alarm, held until released and reset [R5]
        if (ss_trip && ss_is_alarm(mode))
            next_cond.ss_alarm = 1'b1;
        else if (reset_req && !sto_act)
            next_cond.ss_alarm = 1'b0;
        // Safe stop warning clears itself with STO [R6]
        next_cond.ss_warn = ss_trip && !ss_is_alarm(mode) && !th_trip;
    end

    // Coast while STO is active or any condition stands [R12]
    assign next_coast = sto_act | (|next_cond);

    ////////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait states, always OKAY

    assign aphase_ok = i_hsel & i_htrans[1] & i_hready;
    assign wr_ctl    = aph.wr && (aph.addr == sts_pkg::OFS_CONTROL);
    assign wr_ist    = aph.wr && (aph.addr == sts_pkg::OFS_IRQ_STATUS);
    assign wr_msk    = aph.wr && (aph.addr == sts_pkg::OFS_IRQ_MASK);

    // Capture address phase; read data is prepared a cycle early
    always_comb
    begin
        next_aph.wr   = aphase_ok & i_hwrite;
        next_aph.addr = word_ofs(i_haddr);
        next_hrdata   = 32'h0000_0000;
        if (aphase_ok && !i_hwrite)
        begin
            unique case (word_ofs(i_haddr))
                sts_pkg::OFS_PRIMARY_ALARM:
                    next_hrdata[sts_pkg::BIT_STOP_FLAG] = cond.ss_alarm;   // [R4]
                sts_pkg::OFS_SECONDARY_ALARM:
                begin
                    next_hrdata[sts_pkg::BIT_STOP_FLAG]   = cond.th_alarm; // [R4]
                    next_hrdata[sts_pkg::BIT_DANGER_FLAG] = cond.danger;
                end
                sts_pkg::OFS_PRIMARY_WARN:
                    next_hrdata[sts_pkg::BIT_STOP_FLAG] = cond.ss_warn;    // [R4]
                sts_pkg::OFS_SECONDARY_WARN:
                    next_hrdata[sts_pkg::BIT_STOP_FLAG] = cond.th_warn;    // [R4]
                sts_pkg::OFS_CONTROL:
                    next_hrdata[sts_pkg::CTL_MODE_LSB +: sts_pkg::CTL_MODE_W] = mode;
                sts_pkg::OFS_IRQ_STATUS:
                    next_hrdata[sts_pkg::EV_W-1:0] = irq_st;
                sts_pkg::OFS_IRQ_MASK:
                    next_hrdata[sts_pkg::EV_W-1:0] = irq_mask;
                sts_pkg::OFS_INPUT_STATE:
                begin
                    next_hrdata[sts_pkg::IN_STO_ACTIVE]  = sto_act;
                    next_hrdata[sts_pkg::IN_FLAG_ACTIVE] = flag_raw;
                    next_hrdata[sts_pkg::IN_COAST]       = o_coast;
                end
                default:
                    next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    // Register writes in the data phase
    always_comb
    begin
        next_mode      = mode;
        next_irq_mask  = irq_mask;
        next_bus_reset = 1'b0;
        if (wr_ctl)
        begin
            // Codes outside 2..9 are ignored, keeping the old mode [R15]
            if ((i_hwdata[3:0] >= sts_pkg::MODE_SAFE_ALARM)
                && (i_hwdata[3:0] <= sts_pkg::MODE_TH_W_ES_A))
                next_mode = i_hwdata[sts_pkg::CTL_MODE_LSB +: sts_pkg::CTL_MODE_W];
            next_bus_reset = i_hwdata[sts_pkg::CTL_RESET_BIT];
        end
        if (wr_msk)
            next_irq_mask = i_hwdata[sts_pkg::EV_W-1:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status: rising conditions set, write one clears, set wins

    always_comb
    begin
        logic [sts_pkg::EV_W-1:0] ev;
        logic [sts_pkg::EV_W-1:0] clr;
        ev = 5'h00;
        clr = wr_ist ? i_hwdata[sts_pkg::EV_W-1:0] : 5'h00;
        ev[sts_pkg::EV_SS_ALARM] = next_cond.ss_alarm & ~cond.ss_alarm;
        ev[sts_pkg::EV_SS_WARN]  = next_cond.ss_warn  & ~cond.ss_warn;
        ev[sts_pkg::EV_TH_ALARM] = next_cond.th_alarm & ~cond.th_alarm;
        ev[sts_pkg::EV_TH_WARN]  = next_cond.th_warn  & ~cond.th_warn;
        ev[sts_pkg::EV_DANGER]   = next_cond.danger   & ~cond.danger;
        next_irq_st = (irq_st & ~clr) | ev;
        next_irq    = |(next_irq_st & next_irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Condition flags and the coast command
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cond    <= '0;
            o_coast <= 1'b0;
        end
        else
        begin
            cond    <= next_cond;
            o_coast <= next_coast;
        end
    end

    // Software settings; the bus reset request lives for one cycle only
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            mode      <= sts_pkg::MODE_RST;
            irq_mask  <= sts_pkg::IRQ_MASK_RST;
            bus_reset <= 1'b0;
        end
        else
        begin
            mode      <= next_mode;
            irq_mask  <= next_irq_mask;
            bus_reset <= next_bus_reset;
        end
    end

    // Interrupt status and line, both from next values so they never disagree
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            irq_st <= 5'h00;
            o_irq  <= 1'b0;
        end
        else
        begin
            irq_st <= next_irq_st;
            o_irq  <= next_irq;
        end
    end

    // Bus side; ready and response are flops too, so every output is registered
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            aph         <= '0;
            o_hrdata    <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
        else
        begin
            aph         <= next_aph;
            o_hrdata    <= next_hrdata;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
        end
    end

endmodule

/* rtl/sts_pkg.sv */
package sts_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register byte offsets (one aligned 32-bit word each)
    localparam logic [7:0] OFS_PRIMARY_ALARM   = 8'h00;
    localparam logic [7:0] OFS_SECONDARY_ALARM = 8'h04;
    localparam logic [7:0] OFS_PRIMARY_WARN    = 8'h08;
    localparam logic [7:0] OFS_SECONDARY_WARN  = 8'h0C;
    localparam logic [7:0] OFS_CONTROL         = 8'h10;
    localparam logic [7:0] OFS_IRQ_STATUS      = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK        = 8'h18;
    localparam logic [7:0] OFS_INPUT_STATE     = 8'h1C;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions in the status words
    localparam int unsigned BIT_STOP_FLAG   = 30;
    localparam int unsigned BIT_DANGER_FLAG = 31;

    // Control word: mode code in [3:0], reset request strobe in bit 8
    localparam int unsigned CTL_MODE_LSB  = 0;
    localparam int unsigned CTL_MODE_W    = 4;
    localparam int unsigned CTL_RESET_BIT = 8;

    // Input state word bit positions
    localparam int unsigned IN_STO_ACTIVE  = 0;
    localparam int unsigned IN_FLAG_ACTIVE = 1;
    localparam int unsigned IN_COAST       = 2;

    // Interrupt event bit positions (same layout for status and mask)
    localparam int unsigned EV_SS_ALARM = 0;
    localparam int unsigned EV_SS_WARN  = 1;
    localparam int unsigned EV_TH_ALARM = 2;
    localparam int unsigned EV_TH_WARN  = 3;
    localparam int unsigned EV_DANGER   = 4;
    localparam int unsigned EV_W        = 5;

    ////////////////////////////////////////////////////////////////////////////
    // Safe-stop mode codes and reset values
    localparam logic [3:0] MODE_SAFE_ALARM   = 4'h2;
    localparam logic [3:0] MODE_SAFE_WARN    = 4'h3;
    localparam logic [3:0] MODE_TH_ALARM     = 4'h4;
    localparam logic [3:0] MODE_TH_WARN      = 4'h5;
    localparam logic [3:0] MODE_TH_ES_ALARM  = 4'h6;
    localparam logic [3:0] MODE_TH_ES_WARN   = 4'h7;
    localparam logic [3:0] MODE_TH_A_ES_W    = 4'h8;
    localparam logic [3:0] MODE_TH_W_ES_A    = 4'h9;
    localparam logic [3:0] MODE_RST          = 4'h2;
    localparam logic [4:0] IRQ_MASK_RST      = 5'h00;

    // Supervisor condition flags
    typedef struct packed {
        logic danger;       // Dangerous failure, trip locked
        logic th_warn;      // Thermistor stop warning
        logic th_alarm;     // Thermistor stop alarm, latched
        logic ss_warn;      // Safe stop warning
        logic ss_alarm;     // Safe stop alarm, latched
    } sts_cond_s;

    // Captured AHB address phase
    typedef struct packed {
        logic       wr;
        logic [7:0] addr;
    } sts_aphase_s;

endpackage

/* rtl/sts_sync2.sv */
`timescale 1ns/100ps

// Two-stage synchroniser; stage one is read only by stage two
module sts_sync2 #(
    parameter int unsigned W = 2
) (
    input  wire logic         i_clk,   // System clock
    input  wire logic         i_rst,   // Async reset, active high
    input  wire logic [W-1:0] i_d,     // Asynchronous levels
    output logic      [W-1:0] o_q      // Synchronised levels
);

    logic [W-1:0] meta;
    logic [W-1:0] next_meta;
    logic [W-1:0] next_q;

    // Shift one stage per edge
    always_comb
    begin
        next_meta = i_d;
        next_q    = meta;
    end

    // Reset to zero; callers choose the idle polarity by inversion
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta <= '0;
            o_q  <= '0;
        end
        else
        begin
            meta <= next_meta;
            o_q  <= next_q;
        end
    end

endmodule

/* tb/sts_card_model.sv */
`timescale 1ns/100ps

// Plug-in card: relay path and trip flag, plus two fault injections
module sts_card_model (
    input  wire logic i_relay_open,  // Thermistor trip, relay path open
    input  wire logic i_sto_only,    // Other device pulls safe stop
    input  wire logic i_flag_only,   // Fault: flag without safe stop
    output logic      o_sto_n,       // Safe stop line, low active
    output logic      o_flag         // Trip flag line, high active
);
    // Both lines move together, so a trip never shows a false pair
    assign o_sto_n = !(i_relay_open || i_sto_only);
    // Sole driver of the flag line; it feeds no other function
    assign o_flag = i_relay_open || i_flag_only;
endmodule

/* tb/sts_checker.sv */
`timescale 1ns/100ps

module sts_checker (
    input wire logic        i_clk,                    // Clock
    input wire logic        i_rst,                    // Reset
    input wire logic        i_hsel,                   // Select
    input wire logic [31:0] i_haddr,                  // Address
    input wire logic [1:0]  i_htrans,                 // Transfer
    input wire logic        i_hwrite,                 // Write
    input wire logic [2:0]  i_hsize,                  // Size
    input wire logic [31:0] i_hwdata,                 // Write data
    input wire logic        i_hready,                 // Bus ready
    input wire logic [31:0] o_hrdata,                 // Read data
    input wire logic        o_hreadyout,              // Slave ready
    input wire logic        o_hresp,                  // Response
    input wire logic        i_sto_n,                  // Safe stop
    input wire logic        i_card_trip_flag_output,  // Trip flag
    input wire logic        i_reset_di,               // Reset input
    input wire logic        i_reset_key,              // Reset key
    input wire logic        o_coast,                  // Coast
    input wire logic        o_irq                     // Interrupt
);
    logic       rd_dp;    // Read data phase
    logic       wr_dp;    // Write data phase
    logic [7:0] dp_addr;  // Data phase address
    logic [3:0] mode;     // Mode as software left it
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    ////////////////////////////////////////////////////////////////////////////
    // Shadow the bus; invalid codes are dropped as the block drops them
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rd_dp <= 1'h0;
            wr_dp <= 1'h0;
            dp_addr <= 8'h00;
            mode <= 4'h2;
        end
        else if (i_hready)
        begin
            rd_dp <= i_hsel && i_htrans[1] && !i_hwrite;
            wr_dp <= i_hsel && i_htrans[1] && i_hwrite;
            dp_addr <= i_haddr[7:0];
            if (wr_dp && dp_addr == 8'h10 && i_hwdata[3:0] inside {[4'h2:4'h9]})
                mode <= i_hwdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    chk_bus_okay: assert property (o_hreadyout && !o_hresp)
        else $error("bus not ready or not okay");
    chk_sto_coast: assert property (!i_sto_n [*4] |-> o_coast)
        else $error("no coast while safe stop held");
    chk_sync_delay: assert property (!o_coast && $fell(i_sto_n) &&
        $stable(i_card_trip_flag_output) |=> !o_coast [*2])
        else $error("coast faster than two sync stages");
    chk_word_bits: assert property (rd_dp && dp_addr < 8'h10 |-> (o_hrdata &
        ~(dp_addr == 8'h04 ? 32'hC0000000 : 32'h40000000)) == 32'h0)
        else $error("status word bit outside its place");
    chk_idle_zero: assert property (!(rd_dp && dp_addr < 8'h20) |-> o_hrdata == 32'h0)
        else $error("read data not zero");
    chk_ctl_read: assert property (rd_dp && dp_addr == 8'h10 |-> o_hrdata == {28'h0, mode})
        else $error("control readback wrong");
    chk_pair_lock: assert property ((mode inside {4'h4, 4'h5} && !i_sto_n &&
        !i_card_trip_flag_output) [*4] |-> o_coast [*8])
        else $error("lone safe stop not locked");
    chk_flag_lock: assert property ((mode >= 4'h6 && i_sto_n &&
        i_card_trip_flag_output) [*4] |-> o_coast [*8])
        else $error("lone trip flag not locked");
    chk_flag_ignored: assert property ((mode < 4'h4 && i_sto_n) [*4] ##0 !o_coast
        ##1 (mode < 4'h4 && i_sto_n) [*4] |-> !o_coast)
        else $error("trip flag acted in safe stop mode");
endmodule

bind sts_supervisor sts_checker u_chk (.i_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_hsize, .i_hwdata, .i_hready, .o_hrdata, .o_hreadyout, .o_hresp,
    .i_sto_n, .i_card_trip_flag_output, .i_reset_di, .i_reset_key, .o_coast, .o_irq);

/* tb/tb_top.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb_top;
    logic        i_clk, i_rst, hsel, hwrite, hready, hresp, coast, irq;
    logic        relay, sto_only, flag_only, sto_n, flag, rst_di, rst_key;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, rdat;
    int          error_cnt, cmp_count;

    // Clock at 100 MHz
    initial
    begin
        i_clk = 1'h0;
        forever #5 i_clk = ~i_clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    sts_supervisor dut (.i_clk(i_clk), .i_rst(i_rst), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .i_sto_n(sto_n), .i_card_trip_flag_output(flag), .i_reset_di(rst_di),
        .i_reset_key(rst_key), .o_coast(coast), .o_irq(irq));
    sts_card_model card (.i_relay_open(relay), .i_sto_only(sto_only),
        .i_flag_only(flag_only), .o_sto_n(sto_n), .o_flag(flag));

    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("compares %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask
    // Bounded wait for hready; a hang ends the run as a failure
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (hready !== 1'h1 && n < 64);
        if (hready !== 1'h1)
        begin
            error_cnt++;
            end_sim();
        end
    endtask
    // One single AHB transfer: address phase, then data phase
    task automatic xfer(input logic is_wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge i_clk);
        hsel <= 1'h1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= is_wr;
        wait_rdy();
        hsel <= 1'h0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rdat = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'h1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'h0, a, 32'h0);
        `CHK(rdat, e)
    endtask
    // Reset request from digital input or panel key, one cycle long
    task automatic req(input logic di);
        @(posedge i_clk);
        rst_di <= di;
        rst_key <= !di;
        @(posedge i_clk);
        rst_di <= 1'h0;
        rst_key <= 1'h0;
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        {i_rst, hsel, haddr, htrans, hwrite, hwdata} = {1'h1, 68'h0};
        {relay, sto_only, flag_only, rst_di, rst_key} = 5'h00;
        {error_cnt, cmp_count} = 64'h0;
        tick(16);
        i_rst <= 1'h0;
        for (int a = 0; a < 8; a++)
            rd(8'(4 * a), a == 4 ? 32'h2 : 32'h0);
        rd(8'h40, 32'h0);
        wr(sts_pkg::OFS_CONTROL, 32'hF);
        rd(sts_pkg::OFS_CONTROL, 32'h2);
        done("reset");
        // Safe stop alarm holds until released and reset; interrupt path
        sto_only <= 1'h1;
        tick(6);
        `CHK(coast, 1'h1)
        rd(sts_pkg::OFS_PRIMARY_ALARM, 32'h40000000);
        rd(sts_pkg::OFS_INPUT_STATE, 32'h5);
        rd(sts_pkg::OFS_IRQ_STATUS, 32'h1);
        `CHK(irq, 1'h0)
        wr(sts_pkg::OFS_IRQ_MASK, 32'h1F);
        tick(2);
        `CHK(irq, 1'h1)
        wr(sts_pkg::OFS_IRQ_STATUS, 32'h1);
        tick(2);
        `CHK(irq, 1'h0)
        req(1'h0);
        tick(4);
        rd(sts_pkg::OFS_PRIMARY_ALARM, 32'h40000000);
        sto_only <= 1'h0;
        tick(8);
        rd(sts_pkg::OFS_PRIMARY_ALARM, 32'h40000000);
        req(1'h0);
        tick(4);
        rd(sts_pkg::OFS_PRIMARY_ALARM, 32'h0);
        done("safe_stop_alarm");
        // Safe stop warning clears by itself
        wr(sts_pkg::OFS_CONTROL, 32'h3);
        sto_only <= 1'h1;
        tick(6);
        rd(sts_pkg::OFS_PRIMARY_WARN, 32'h40000000);
        sto_only <= 1'h0;
        tick(6);
        rd(sts_pkg::OFS_PRIMARY_WARN, 32'h0);
        `CHK(coast, 1'h0)
        done("safe_stop_warning");
        // Flag ignored in mode 2, card still forces a stop; bus reset
        wr(sts_pkg::OFS_CONTROL, 32'h2);
        flag_only <= 1'h1;
        tick(6);
        rd(sts_pkg::OFS_SECONDARY_ALARM, 32'h0);
        `CHK(coast, 1'h0)
        rd(sts_pkg::OFS_INPUT_STATE, 32'h2);
        {relay, flag_only} <= 2'h2;
        tick(6);
        rd(sts_pkg::OFS_PRIMARY_ALARM, 32'h40000000);
        relay <= 1'h0;
        tick(6);
        wr(sts_pkg::OFS_CONTROL, 32'h102);
        tick(2);
        rd(sts_pkg::OFS_PRIMARY_ALARM, 32'h0);
        done("flag_ignored");
        // Thermistor alarm needs both lines released before a reset
        wr(sts_pkg::OFS_CONTROL, 32'h4);
        relay <= 1'h1;
        tick(6);
        rd(sts_pkg::OFS_SECONDARY_ALARM, 32'h40000000);
        req(1'h1);
        tick(4);
        rd(sts_pkg::OFS_SECONDARY_ALARM, 32'h40000000);
        relay <= 1'h0;
        tick(6);
        rd(sts_pkg::OFS_SECONDARY_ALARM, 32'h40000000);
        req(1'h1);
        tick(4);
        rd(sts_pkg::OFS_SECONDARY_ALARM, 32'h0);
        // Thermistor warning restarts without a reset
        wr(sts_pkg::OFS_CONTROL, 32'h5);
        relay <= 1'h1;
        tick(6);
        rd(sts_pkg::OFS_SECONDARY_WARN, 32'h40000000);
        relay <= 1'h0;
        tick(6);
        rd(sts_pkg::OFS_SECONDARY_WARN, 32'h0);
        `CHK(coast, 1'h0)
        done("thermistor");
        // Every thermistor mode against both lone-line faults
        for (int m = 4; m < 10; m++)
            for (int f = 0; f < 2; f++)
            begin
                i_rst <= 1'h1;
                tick(2);
                i_rst <= 1'h0;
                wr(sts_pkg::OFS_CONTROL, 32'(m));
                {sto_only, flag_only} <= (f == 0) ? 2'h2 : 2'h1;
                tick(6);
                {sto_only, flag_only} <= 2'h0;
                tick(4);
                req(1'h0);
                tick(4);
                rd(sts_pkg::OFS_SECONDARY_ALARM, (m < 6 || f == 1) ? 32'h80000000 : 32'h0);
            end
        done("dangerous_failure");
        end_sim();
    end
endmodule
